/* File: common/lic_consts.svh */
// Purpose: Offsets, field positions, reset values and codes of the lane register slice
// Assumes: Byte addresses on a 32-bit classic Wishbone bus
// Notes:   Included by the package, the register bank and its property checker
`ifndef LIC_CONSTS_SVH
`define LIC_CONSTS_SVH

// ----------------------------------------------------------------
// Address map
// ----------------------------------------------------------------
`define LIC_ADDR_W            8
`define LIC_OFS_TX_PHASE      8'h00
`define LIC_OFS_TX_SPARE      8'h04
`define LIC_OFS_CTRL          8'h08
`define LIC_OFS_BUF_LVL       8'h10
`define LIC_OFS_LANE_ID       8'h14
`define LIC_OFS_ERR_A         8'h18
`define LIC_OFS_ERR_B         8'h1C
`define LIC_OFS_LINK_ERR      8'h20
`define LIC_OFS_TEST_ERR      8'h24
`define LIC_OFS_TEST_ILA      8'h28
`define LIC_OFS_RX_ADJ        8'h2C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LIC_ADJUST_DIRECTION_BIT        16
`define LIC_PHASE_ADJUST_REQUEST_BIT         8
`define LIC_ADJUST_STEP_COUNT_LSB        0
`define LIC_SPARE_TWO_LSB     8
`define LIC_SPARE_ONE_LSB     0
`define LIC_LANE_ID_LSB       0
`define LIC_LANE_SEL_LSB      0
`define LIC_LINK_EN_BIT       8
`define LIC_TEST_MODE_LSB     16
`define LIC_CODING64_BIT      24
`define LIC_CRC_LSB           16
`define LIC_MBA_LSB           8
`define LIC_SHA_LSB           0
`define LIC_FEC_UNC_LSB       16
`define LIC_FEC_COR_LSB       0

// ----------------------------------------------------------------
// Widths, reset values and codes
// ----------------------------------------------------------------
`define LIC_LANE_SEL_W        3
`define LIC_BUF_BYTES_W       13
`define LIC_BUF_LVL_W         10
`define LIC_WORD_SHIFT        3
`define LIC_ADJUST_STEP_COUNT_RST        4'h0
`define LIC_SPARE_RST         8'h00
`define LIC_TM_OFF            3'h0
`define LIC_TM_COMMA          3'h1
`define LIC_TM_ILAS           3'h2
`define LIC_COMMA_CHAR        8'hBC
`define LIC_RDATA_RST         32'h0000_0000

`endif

/* File: common/lic_pkg.sv */
// Purpose: Types carried between the lane register slice and its neighbours
// Assumes: Constants come from lic_consts.svh
// Notes:   No imports; users write lic_pkg::name
`include "lic_consts.svh"

package lic_pkg;

   // Transmit alignment fields, common to all lanes
   typedef struct packed {
      logic       adjust_direction;
      logic       phase_adjust_request;
      logic [3:0] adjust_step_count;
      logic [7:0] spare_field_two;
      logic [7:0] spare_field_one;
   } lic_tx_ila_t;

   // Software controls that steer the lanes
   typedef struct packed {
      logic                       coding64;
      logic [2:0]                 test_mode;
      logic                       link_err_en;
      logic [`LIC_LANE_SEL_W-1:0] lane_sel;
   } lic_ctrl_t;

   // Per-lane events and status from the receive datapath
   typedef struct packed {
      logic                        crc_err;
      logic                        mb_align_err;
      logic                        sh_align_err;
      logic                        fec_uncorrected;
      logic                        fec_corrected;
      logic                        code_err;
      logic                        char_valid;
      logic                        char_is_k;
      logic [7:0]                  char_data;
      logic                        char_mismatch;
      logic                        ilas_done;
      logic                        adj_valid;
      logic [3:0]                  adj_cnt;
      logic [`LIC_BUF_BYTES_W-1:0] buf_bytes;
   } lic_lane_evt_t;

endpackage : lic_pkg

/* File: hw/lic_sat_ctr.sv */
// Purpose: Saturating event counter with clear
// Assumes: inc and clr are synchronous single-cycle terms
// Notes:   An event in the clear cycle leaves a count of one
`timescale 1ns/1ps

module lic_sat_ctr #(
   parameter int WIDTH = 32
) (
   input  wire logic             core_clk,
   input  wire logic             reset_n,
   input  wire logic             clk_en,
   input  wire logic             inc,
   input  wire logic             clr,
   output logic [WIDTH-1:0]      count
);

   typedef struct packed {
      logic [WIDTH-1:0] count;
   } lic_ctr_st_t;

   lic_ctr_st_t st_reg;
   lic_ctr_st_t st_next;

   always_comb begin
      st_next = st_reg;
      if (clr) begin
         st_next.count = inc ? WIDTH'(1) : '0;
      end else if (inc && !(&st_reg.count)) begin
         st_next.count = st_reg.count + WIDTH'(1);
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg <= '0;
      end else if (clk_en) begin
         st_reg <= st_next;
      end
   end

   assign count = st_reg.count;

endmodule : lic_sat_ctr

/* File: hw/lic_wb_if.sv */
// Purpose: Classic Wishbone handshake for a single-cycle slave
// Assumes: Master holds the request until it samples ack
// Notes:   access pulses once per request, one cycle before ack
`timescale 1ns/1ps

module lic_wb_if (
   input  wire logic core_clk,
   input  wire logic reset_n,
   input  wire logic clk_en,
   input  wire logic wb_cyc_i,
   input  wire logic wb_stb_i,
   output logic      wb_ack_o,
   output logic      access
);

   typedef struct packed {
      logic ack;
   } lic_wb_st_t;

   lic_wb_st_t st_reg;
   lic_wb_st_t st_next;

   always_comb begin
      st_next     = st_reg;
      st_next.ack = wb_cyc_i && wb_stb_i && !st_reg.ack;
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg <= '0;
      end else if (clk_en) begin
         st_reg <= st_next;
      end
   end

   assign access   = clk_en && wb_cyc_i && wb_stb_i && !st_reg.ack;
   assign wb_ack_o = st_reg.ack;

endmodule : lic_wb_if

/* File: hw/lic_regbank.sv */
// Purpose: Lane alignment configuration and per-lane receive error counters
// Assumes: Wishbone classic slave, one clock, events synchronous to core_clk
// Notes:   Per-lane registers are seen through the lane selected in the control word
//
// Chosen here: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`include "lic_consts.svh"

module lic_regbank #(
   parameter int NUM_LANES = 8
) (
   input  wire logic                                core_clk,
   input  wire logic                                reset_n,
   input  wire logic                                clk_en,
   input  wire logic                                wb_cyc_i,
   input  wire logic                                wb_stb_i,
   input  wire logic                                wb_we_i,
   input  wire logic [`LIC_ADDR_W-1:0]              wb_adr_i,
   input  wire logic [3:0]                          wb_sel_i,
   input  wire logic [31:0]                         wb_dat_i,
   output logic      [31:0]                         wb_dat_o,
   output logic                                     wb_ack_o,
   input  wire lic_pkg::lic_lane_evt_t [NUM_LANES-1:0] lane_evt,
   output lic_pkg::lic_tx_ila_t                     tx_ila,
   output lic_pkg::lic_ctrl_t                       ctrl,
   output logic      [NUM_LANES-1:0][4:0]           tx_lane_id
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      lic_pkg::lic_tx_ila_t          tx;
      lic_pkg::lic_ctrl_t            ctrl;
      logic [2:0]                    prev_mode;
      logic                          prev_link_en;
      logic [NUM_LANES-1:0][4:0]     lane_id;
      logic [NUM_LANES-1:0][3:0]     rx_adj;
      logic [31:0]                   rdata;
   } lic_st_t;

   function automatic lic_st_t reset_state();
      lic_st_t s;
      s                            = '0;
      s.tx.adjust_direction        = 1'b0;
      s.tx.phase_adjust_request    = 1'b0;
      s.tx.adjust_step_count       = `LIC_ADJUST_STEP_COUNT_RST;
      s.tx.spare_field_two         = `LIC_SPARE_RST;
      s.tx.spare_field_one         = `LIC_SPARE_RST;
      s.ctrl.test_mode             = `LIC_TM_OFF;
      s.prev_mode                  = `LIC_TM_OFF;
      s.rdata                      = `LIC_RDATA_RST;
      for (int i = 0; i < NUM_LANES; i++) begin
         s.lane_id[i] = 5'(i);
      end
      return s;
   endfunction : reset_state

   localparam lic_st_t ST_RESET = reset_state();

   function automatic logic [31:0] merge(
      input logic [31:0] old,
      input logic [31:0] dat,
      input logic [3:0]  sel
   );
      logic [31:0] m;
      m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
      return (old & ~m) | (dat & m);
   endfunction : merge

   lic_st_t st_reg;
   lic_st_t st_next;

   logic                             access;
   logic                             rd_acc;
   logic                             wr_acc;
   logic [`LIC_LANE_SEL_W-1:0]       sel_idx;
   logic                             lane_ok;
   logic                             entering_active;
   logic                             entering_ilas;
   logic                             link_restart;

   logic [NUM_LANES-1:0][15:0]       crc_cnt;
   logic [NUM_LANES-1:0][7:0]        mba_cnt;
   logic [NUM_LANES-1:0][7:0]        sha_cnt;
   logic [NUM_LANES-1:0][15:0]       fecu_cnt;
   logic [NUM_LANES-1:0][15:0]       fecc_cnt;
   logic [NUM_LANES-1:0][31:0]       link_cnt;
   logic [NUM_LANES-1:0][31:0]       terr_cnt;
   logic [NUM_LANES-1:0][31:0]       tila_cnt;
   logic [NUM_LANES-1:0][`LIC_BUF_LVL_W-1:0] buf_lvl;

   // ----------------------------------------------------------------
   // Bus handshake
   // ----------------------------------------------------------------
   lic_wb_if u_wb_if (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .clk_en   (clk_en),
      .wb_cyc_i (wb_cyc_i),
      .wb_stb_i (wb_stb_i),
      .wb_ack_o (wb_ack_o),
      .access   (access)
   );

   assign rd_acc  = access && !wb_we_i;
   assign wr_acc  = access && wb_we_i;
   assign lane_ok = int'(st_reg.ctrl.lane_sel) < NUM_LANES;
   assign sel_idx = lane_ok ? st_reg.ctrl.lane_sel : '0;

   // Mode entry and link counter restart, seen one cycle after the write
   assign entering_active = (st_reg.ctrl.test_mode != `LIC_TM_OFF)
                            && (st_reg.ctrl.test_mode != st_reg.prev_mode);
   assign entering_ilas   = (st_reg.ctrl.test_mode == `LIC_TM_ILAS)
                            && (st_reg.prev_mode != `LIC_TM_ILAS);
   assign link_restart    = st_reg.ctrl.link_err_en && !st_reg.prev_link_en;

   // ----------------------------------------------------------------
   // Per-lane counters
   // ----------------------------------------------------------------
   for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
      logic clr_a;
      logic clr_b;
      logic t_inc;
      logic comma_bad;

      assign clr_a = rd_acc && lane_ok && (wb_adr_i == `LIC_OFS_ERR_A)
                     && (int'(sel_idx) == g);
      assign clr_b = rd_acc && lane_ok && (wb_adr_i == `LIC_OFS_ERR_B)
                     && (int'(sel_idx) == g);

      assign comma_bad = lane_evt[g].char_valid
                         && !(lane_evt[g].char_is_k
                              && lane_evt[g].char_data == `LIC_COMMA_CHAR);
      assign t_inc = ((st_reg.ctrl.test_mode == `LIC_TM_COMMA) && comma_bad)
                     || ((st_reg.ctrl.test_mode == `LIC_TM_ILAS)
                         && lane_evt[g].char_mismatch);

      assign buf_lvl[g] = st_reg.ctrl.coding64
                          ? `LIC_BUF_LVL_W'(lane_evt[g].buf_bytes >> `LIC_WORD_SHIFT)
                          : `LIC_BUF_LVL_W'(lane_evt[g].buf_bytes);

      lic_sat_ctr #(.WIDTH(16)) u_crc (
         .core_clk (core_clk), .reset_n (reset_n), .clk_en (clk_en),
         .inc (lane_evt[g].crc_err), .clr (clr_a), .count (crc_cnt[g])
      );
      lic_sat_ctr #(.WIDTH(8)) u_mba (
         .core_clk (core_clk), .reset_n (reset_n), .clk_en (clk_en),
         .inc (lane_evt[g].mb_align_err), .clr (clr_a), .count (mba_cnt[g])
      );
      lic_sat_ctr #(.WIDTH(8)) u_sha (
         .core_clk (core_clk), .reset_n (reset_n), .clk_en (clk_en),
         .inc (lane_evt[g].sh_align_err), .clr (clr_a), .count (sha_cnt[g])
      );
      lic_sat_ctr #(.WIDTH(16)) u_fecu (
         .core_clk (core_clk), .reset_n (reset_n), .clk_en (clk_en),
         .inc (lane_evt[g].fec_uncorrected), .clr (clr_b), .count (fecu_cnt[g])
      );
      lic_sat_ctr #(.WIDTH(16)) u_fecc (
         .core_clk (core_clk), .reset_n (reset_n), .clk_en (clk_en),
         .inc (lane_evt[g].fec_corrected), .clr (clr_b), .count (fecc_cnt[g])
      );
      lic_sat_ctr #(.WIDTH(32)) u_link (
         .core_clk (core_clk), .reset_n (reset_n), .clk_en (clk_en),
         .inc (st_reg.ctrl.link_err_en && lane_evt[g].code_err),
         .clr (link_restart), .count (link_cnt[g])
      );
      lic_sat_ctr #(.WIDTH(32)) u_terr (
         .core_clk (core_clk), .reset_n (reset_n), .clk_en (clk_en),
         .inc (t_inc), .clr (entering_active), .count (terr_cnt[g])
      );
      lic_sat_ctr #(.WIDTH(32)) u_tila (
         .core_clk (core_clk), .reset_n (reset_n), .clk_en (clk_en),
         .inc ((st_reg.ctrl.test_mode == `LIC_TM_ILAS) && lane_evt[g].ilas_done),
         .clr (entering_ilas), .count (tila_cnt[g])
      );
   end

   // ----------------------------------------------------------------
   // Register images
   // ----------------------------------------------------------------
   logic [31:0] img_phase;
   logic [31:0] img_spare;
   logic [31:0] img_ctrl;

   always_comb begin
      img_phase = (32'(st_reg.tx.adjust_direction) << `LIC_ADJUST_DIRECTION_BIT)
                  | (32'(st_reg.tx.phase_adjust_request) << `LIC_PHASE_ADJUST_REQUEST_BIT)
                  | (32'(st_reg.tx.adjust_step_count) << `LIC_ADJUST_STEP_COUNT_LSB);
      img_spare = (32'(st_reg.tx.spare_field_two) << `LIC_SPARE_TWO_LSB)
                  | (32'(st_reg.tx.spare_field_one) << `LIC_SPARE_ONE_LSB);
      img_ctrl  = (32'(st_reg.ctrl.coding64) << `LIC_CODING64_BIT)
                  | (32'(st_reg.ctrl.test_mode) << `LIC_TEST_MODE_LSB)
                  | (32'(st_reg.ctrl.link_err_en) << `LIC_LINK_EN_BIT)
                  | (32'(st_reg.ctrl.lane_sel) << `LIC_LANE_SEL_LSB);
   end

   // ----------------------------------------------------------------
   // Next state: writes, read data, lane captures
   // ----------------------------------------------------------------
   always_comb begin
      logic [31:0] w;
      logic [31:0] rd;
      w       = '0;
      rd      = '0;
      st_next = st_reg;

      st_next.prev_mode    = st_reg.ctrl.test_mode;
      st_next.prev_link_en = st_reg.ctrl.link_err_en;

      for (int i = 0; i < NUM_LANES; i++) begin
         if (lane_evt[i].adj_valid) begin
            st_next.rx_adj[i] = lane_evt[i].adj_cnt;
         end
      end

      if (wr_acc) begin
         unique case (wb_adr_i)
            `LIC_OFS_TX_PHASE: begin
               w = merge(img_phase, wb_dat_i, wb_sel_i);
               st_next.tx.adjust_direction     = w[`LIC_ADJUST_DIRECTION_BIT];
               st_next.tx.phase_adjust_request = w[`LIC_PHASE_ADJUST_REQUEST_BIT];
               st_next.tx.adjust_step_count    = w[`LIC_ADJUST_STEP_COUNT_LSB +: 4];
            end
            `LIC_OFS_TX_SPARE: begin
               w = merge(img_spare, wb_dat_i, wb_sel_i);
               st_next.tx.spare_field_two = w[`LIC_SPARE_TWO_LSB +: 8];
               st_next.tx.spare_field_one = w[`LIC_SPARE_ONE_LSB +: 8];
            end
            `LIC_OFS_CTRL: begin
               w = merge(img_ctrl, wb_dat_i, wb_sel_i);
               st_next.ctrl.coding64    = w[`LIC_CODING64_BIT];
               st_next.ctrl.test_mode   = w[`LIC_TEST_MODE_LSB +: 3];
               st_next.ctrl.link_err_en = w[`LIC_LINK_EN_BIT];
               st_next.ctrl.lane_sel    = w[`LIC_LANE_SEL_LSB +: `LIC_LANE_SEL_W];
            end
            `LIC_OFS_LANE_ID: begin
               if (lane_ok) begin
                  w = merge(32'(st_reg.lane_id[sel_idx]), wb_dat_i, wb_sel_i);
                  st_next.lane_id[sel_idx] = w[`LIC_LANE_ID_LSB +: 5];
               end
            end
            default: begin
            end
         endcase
      end

      if (rd_acc) begin
         unique case (wb_adr_i)
            `LIC_OFS_TX_PHASE: rd = img_phase;
            `LIC_OFS_TX_SPARE: rd = img_spare;
            `LIC_OFS_CTRL:     rd = img_ctrl;
            `LIC_OFS_BUF_LVL:  rd = 32'(buf_lvl[sel_idx]);
            `LIC_OFS_LANE_ID:  rd = 32'(st_reg.lane_id[sel_idx]);
            `LIC_OFS_ERR_A:    rd = (32'(crc_cnt[sel_idx]) << `LIC_CRC_LSB)
                                    | (32'(mba_cnt[sel_idx]) << `LIC_MBA_LSB)
                                    | (32'(sha_cnt[sel_idx]) << `LIC_SHA_LSB);
            `LIC_OFS_ERR_B:    rd = (32'(fecu_cnt[sel_idx]) << `LIC_FEC_UNC_LSB)
                                    | (32'(fecc_cnt[sel_idx]) << `LIC_FEC_COR_LSB);
            `LIC_OFS_LINK_ERR: rd = link_cnt[sel_idx];
            `LIC_OFS_TEST_ERR: rd = terr_cnt[sel_idx];
            `LIC_OFS_TEST_ILA: rd = tila_cnt[sel_idx];
            `LIC_OFS_RX_ADJ:   rd = 32'(st_reg.rx_adj[sel_idx]);
            default:           rd = '0;
         endcase
         if (!lane_ok && wb_adr_i >= `LIC_OFS_BUF_LVL) begin
            rd = '0;
         end
         st_next.rdata = rd;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg <= ST_RESET;
      end else if (clk_en) begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign wb_dat_o   = st_reg.rdata;
   assign tx_ila     = st_reg.tx;
   assign ctrl       = st_reg.ctrl;
   assign tx_lane_id = st_reg.lane_id;

endmodule : lic_regbank

/* File: dv/lic_lane_model.sv */
// Purpose: Remote converter side of the lanes, events into the slice
// Assumes: One event per call step, an idle cycle after each
// Notes:   Fill level differs per lane; idle char data is inverted
`timescale 1ns/1ps
module lic_lane_model #(parameter int NUM_LANES = 8) (
   input  wire logic                              core_clk,
   output lic_pkg::lic_lane_evt_t [NUM_LANES-1:0] lane_evt
);
   lic_pkg::lic_lane_evt_t [NUM_LANES-1:0] pulse_reg = '0;
   always_comb begin
      for (int i = 0; i < NUM_LANES; i++) begin
         lane_evt[i]           = pulse_reg[i];
         lane_evt[i].buf_bytes = 13'h02C0 + 13'(i);
      end
   end
   task automatic send(input int ln, input int kind, input int n, input logic [8:0] ch);
      lic_pkg::lic_lane_evt_t ev;
      repeat (n) begin
         ev = '0;
         case (kind)
            0: ev.crc_err = 1'b1;
            1: ev.mb_align_err = 1'b1;
            2: ev.sh_align_err = 1'b1;
            3: ev.fec_uncorrected = 1'b1;
            4: ev.fec_corrected = 1'b1;
            5: ev.code_err = 1'b1;
            6: ev.char_mismatch = 1'b1;
            7: ev.ilas_done = 1'b1;
            8: {ev.adj_valid, ev.adj_cnt} = {1'b1, ch[3:0]};
            default: {ev.char_valid, ev.char_is_k, ev.char_data} = {1'b1, ch};
         endcase
         @(posedge core_clk);
         pulse_reg[ln] <= ev;
         ev = '0;
         ev.char_data = ~ch[7:0];
         @(posedge core_clk);
         pulse_reg[ln] <= ev;
      end
   endtask : send
endmodule : lic_lane_model

/* File: dv/lic_regbank_properties.sv */
// Purpose: Bus and register relations of the lane register slice
// Assumes: Bound to lic_regbank
// Notes:   Sees only the top module's ports
`timescale 1ns/1ps
`include "lic_consts.svh"
module lic_regbank_properties #(parameter int NUM_LANES = 8) (
   input wire logic                                  core_clk,
   input wire logic                                  reset_n,
   input wire logic                                  clk_en,
   input wire logic                                  wb_cyc_i,
   input wire logic                                  wb_stb_i,
   input wire logic                                  wb_we_i,
   input wire logic [`LIC_ADDR_W-1:0]                wb_adr_i,
   input wire logic [3:0]                            wb_sel_i,
   input wire logic [31:0]                           wb_dat_i,
   input wire logic [31:0]                           wb_dat_o,
   input wire logic                                  wb_ack_o,
   input wire lic_pkg::lic_lane_evt_t [NUM_LANES-1:0] lane_evt,
   input wire lic_pkg::lic_tx_ila_t                  tx_ila,
   input wire lic_pkg::lic_ctrl_t                    ctrl,
   input wire logic [NUM_LANES-1:0][4:0]             tx_lane_id
);
   logic       req;
   logic       wr;
   logic [9:0] lvl_now;
   assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & clk_en;
   assign wr  = req & wb_we_i & (wb_sel_i == 4'hF);
   always_comb lvl_now = ctrl.coding64 ? 10'(lane_evt[ctrl.lane_sel].buf_bytes >> 3)
                                       : lane_evt[ctrl.lane_sel].buf_bytes[9:0];
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   ack_after_req_a: assert property (req |=> wb_ack_o) else $error("no ack");
   ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
   rdata_hold_a: assert property (!req |=> $stable(wb_dat_o)) else $error("rdata moved");
   phase_write_a: assert property (wr && wb_adr_i == 8'h00 |=>
      {tx_ila.adjust_direction, tx_ila.phase_adjust_request, tx_ila.adjust_step_count}
      == {$past(wb_dat_i[16]), $past(wb_dat_i[8]), $past(wb_dat_i[3:0])}) else $error("phase");
   spare_write_a: assert property (wr && wb_adr_i == 8'h04 |=>
      {tx_ila.spare_field_two, tx_ila.spare_field_one} == $past(wb_dat_i[15:0]))
      else $error("spare");
   tx_ila_stable_a: assert property (!(req && wb_we_i && wb_adr_i inside {8'h00, 8'h04}) |=>
      $stable(tx_ila)) else $error("tx_ila moved");
   buf_level_a: assert property (req && !wb_we_i && wb_adr_i == 8'h10 &&
      ctrl.lane_sel < NUM_LANES |=> wb_dat_o == {22'h00_0000, $past(lvl_now)})
      else $error("fill level");
   lane_id_a: assert property (req && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h14 &&
      ctrl.lane_sel < NUM_LANES |=> tx_lane_id[ctrl.lane_sel] == $past(wb_dat_i[4:0]))
      else $error("lane id");
   unmapped_zero_a: assert property (req && !wb_we_i && wb_adr_i == 8'h0C |=>
      wb_dat_o == 32'h0000_0000) else $error("unmapped");
   cov_read: cover property (req && !wb_we_i && wb_adr_i == 8'h10);
   cov_id: cover property (req && wb_we_i && wb_adr_i == 8'h14);
   cov_link: cover property ($rose(ctrl.link_err_en));
endmodule : lic_regbank_properties
bind lic_regbank lic_regbank_properties #(.NUM_LANES(NUM_LANES)) lic_regbank_properties_inst (
   .core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .lane_evt(lane_evt),
   .tx_ila(tx_ila), .ctrl(ctrl), .tx_lane_id(tx_lane_id));

/* File: dv/tb_lic_regbank.sv */
// Purpose: Register sequences with expected values for the lane slice
// Assumes: Wishbone classic master, lane events from the lane model
// Notes:   Run is under three hundred cycles
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
   $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_lic_regbank;
   localparam int NL = 8;
   logic                            core_clk, reset_n, clk_en, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0]                      wb_adr_i;
   logic [3:0]                      wb_sel_i;
   logic [31:0]                     wb_dat_i, wb_dat_o, rd;
   lic_pkg::lic_lane_evt_t [NL-1:0] lane_evt;
   lic_pkg::lic_tx_ila_t            tx_ila;
   lic_pkg::lic_ctrl_t              ctrl;
   logic [NL-1:0][4:0]              tx_lane_id;
   int                              failures, n_tests, cycles;
   lic_regbank #(.NUM_LANES(NL)) lic_regbank_inst (.core_clk(core_clk), .reset_n(reset_n),
      .clk_en(clk_en), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .lane_evt(lane_evt), .tx_ila(tx_ila), .ctrl(ctrl),
      .tx_lane_id(tx_lane_id));
   lic_lane_model #(.NUM_LANES(NL)) lic_lane_model_inst (.core_clk(core_clk), .lane_evt(lane_evt));
   always #20 core_clk = ~core_clk;
   // ----------------------------------------------------------------
   // Bus tasks
   // ----------------------------------------------------------------
   task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
      @(posedge core_clk);
      while (wb_ack_o !== 1'b1) @(posedge core_clk);
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
      @(posedge core_clk);
   endtask : wb_cycle
   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      wb_cycle(1'b0, a, 32'h0000_0000);
      `CHK(nm, e, rd)
   endtask : rchk
   task automatic setc(input logic [2:0] ln, input logic le, input logic [2:0] tm, input logic c);
      wb_cycle(1'b1, 8'h08, {7'h00, c, 5'h00, tm, 7'h00, le, 5'h00, ln});
   endtask : setc
   task automatic tally_and_finish;
      $display("comparisons %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : tally_and_finish
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         tally_and_finish();
      end
   end
   // ----------------------------------------------------------------
   // Sequences
   // ----------------------------------------------------------------
   initial begin
      {core_clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
      {clk_en, wb_sel_i, failures, n_tests, cycles} = {5'h1F, 96'h0};
      repeat (4) @(posedge core_clk);
      reset_n <= 1'b1;
      for (int i = 0; i < NL; i++) begin
         setc(i[2:0], 1'b0, 3'h0, 1'b0);
         rchk("lane_id", 8'h14, 32'(i));
      end
      rchk("phase", 8'h00, 32'h0000_0000);
      wb_cycle(1'b1, 8'h00, 32'hFFFF_FFFF);
      rchk("phase", 8'h00, 32'h0001_010F);
      wb_cycle(1'b1, 8'h04, 32'hFFFF_FFFF);
      rchk("spare", 8'h04, 32'h0000_FFFF);
      `CHK("tx_ila", 22'h3F_FFFF, tx_ila)
      setc(3'h5, 1'b0, 3'h0, 1'b0);
      wb_cycle(1'b1, 8'h14, 32'h0000_003F);
      rchk("lane_id", 8'h14, 32'h0000_001F);
      `CHK("lane_id_port", 5'h1F, tx_lane_id[5])
      setc(3'h6, 1'b0, 3'h0, 1'b0);
      rchk("fill_bytes", 8'h10, 32'h0000_02C6);
      setc(3'h6, 1'b0, 3'h0, 1'b1);
      rchk("fill_words", 8'h10, 32'h0000_0058);
      `CHK("ctrl", 8'h86, ctrl)
      lic_lane_model_inst.send(1, 8, 1, 9'h00A);
      setc(3'h1, 1'b0, 3'h0, 1'b0);
      rchk("rx_adjust", 8'h2C, 32'h0000_000A);
      for (int k = 0; k < 5; k++) lic_lane_model_inst.send(3, k, k == 4 ? 4 : 3 - k % 3, 9'h000);
      setc(3'h3, 1'b0, 3'h0, 1'b0);
      rchk("err_a", 8'h18, 32'h0003_0201);
      rchk("err_a_clr", 8'h18, 32'h0000_0000);
      rchk("err_b", 8'h1C, 32'h0003_0004);
      setc(3'h4, 1'b0, 3'h0, 1'b0);
      rchk("err_a_lane4", 8'h18, 32'h0000_0000);
      lic_lane_model_inst.send(4, 5, 2, 9'h000);
      setc(3'h4, 1'b1, 3'h0, 1'b0);
      lic_lane_model_inst.send(4, 5, 3, 9'h000);
      setc(3'h4, 1'b0, 3'h0, 1'b0);
      lic_lane_model_inst.send(4, 5, 1, 9'h000);
      rchk("link_err", 8'h20, 32'h0000_0003);
      setc(3'h4, 1'b1, 3'h0, 1'b0);
      rchk("link_err_clr", 8'h20, 32'h0000_0000);
      setc(3'h0, 1'b0, 3'h1, 1'b0);
      lic_lane_model_inst.send(0, 9, 2, 9'h1BC);
      lic_lane_model_inst.send(0, 9, 1, 9'h0BC);
      lic_lane_model_inst.send(0, 9, 1, 9'h17C);
      rchk("test_err", 8'h24, 32'h0000_0002);
      setc(3'h0, 1'b0, 3'h2, 1'b0);
      rchk("test_err_entry", 8'h24, 32'h0000_0000);
      lic_lane_model_inst.send(0, 6, 3, 9'h000);
      lic_lane_model_inst.send(0, 7, 2, 9'h000);
      setc(3'h0, 1'b0, 3'h0, 1'b0);
      lic_lane_model_inst.send(0, 6, 1, 9'h000);
      lic_lane_model_inst.send(0, 7, 1, 9'h000);
      rchk("test_err_held", 8'h24, 32'h0000_0003);
      rchk("ila_held", 8'h28, 32'h0000_0002);
      setc(3'h0, 1'b0, 3'h2, 1'b0);
      rchk("ila_entry", 8'h28, 32'h0000_0000);
      rchk("unmapped", 8'h0C, 32'h0000_0000);
      tally_and_finish();
   end
endmodule : tb_lic_regbank
